// *** common/rlp_pkg.sv ***
// package: constants and types of the redriver link fsm
package rlp_pkg;

  // clock and timing figures
  localparam int unsigned CLK_MHZ         = 250;
  localparam int unsigned CLK_PERIOD_NS   = 4;
  localparam int unsigned RETRY_MS        = 12;
  localparam int unsigned RETRY_CYC       = RETRY_MS * CLK_MHZ * 1000;
  localparam int unsigned U2U3_IDLE_US    = 300;
  localparam int unsigned U2U3_IDLE_CYC   = U2U3_IDLE_US * CLK_MHZ;
  localparam int unsigned IDLE_NS         = 6;
  localparam int unsigned IDLE_CYC        = IDLE_NS / CLK_PERIOD_NS;
  localparam int unsigned SLEEP_ENTRY_NS  = 2000;
  localparam int unsigned SLEEP_ENTRY_CYC = SLEEP_ENTRY_NS / CLK_PERIOD_NS;
  localparam int unsigned WAKE_US         = 100;
  localparam int unsigned WAKE_CYC        = WAKE_US * CLK_MHZ;

  // register byte offsets
  localparam logic [11:0] OFF_CTRL    = 12'h000;
  localparam logic [11:0] OFF_STATUS  = 12'h004;
  localparam logic [11:0] OFF_STRAP   = 12'h008;
  localparam logic [11:0] OFF_SETTING = 12'h00C;

  // control register fields and reset value
  localparam int unsigned CTRL_TRACK_BIT    = 0;
  localparam int unsigned CTRL_REDETECT_BIT = 1;
  localparam logic [31:0] CTRL_RESET        = 32'h0000_0001;

  // status register field positions
  localparam int unsigned ST_STATE_LSB   = 0;
  localparam int unsigned ST_FOUND_LSB   = 3;
  localparam int unsigned ST_IDLE_LSB    = 5;
  localparam int unsigned ST_SLEEP_BIT   = 7;
  localparam int unsigned ST_RXTERM_LSB  = 8;
  localparam int unsigned ST_TXTERM_LSB  = 10;
  localparam int unsigned ST_U2U3_BIT    = 12;

  // three-level strap reading
  typedef enum logic [1:0] {
    RLP_LVL_FLOAT = 2'b00,
    RLP_LVL_LOW   = 2'b01,
    RLP_LVL_HIGH  = 2'b10
  } rlp_level_e;

  // link power states
  typedef enum logic [2:0] {
    RLP_ST_START   = 3'b000,
    RLP_ST_SLEEP   = 3'b001,
    RLP_ST_HIZ     = 3'b010,
    RLP_ST_SENSE   = 3'b011,
    RLP_ST_NODET   = 3'b100,
    RLP_ST_ACTIVE  = 3'b101,
    RLP_ST_U2U3    = 3'b110,
    RLP_ST_U2SENSE = 3'b111
  } rlp_state_e;

  // one channel's straps as read from the pins
  typedef struct packed {
    logic [1:0] input_gain_select;
    logic [1:0] output_emphasis_select;
    logic [1:0] output_swing_select;
  } rlp_strap_s;

  // one channel's decoded conditioning setting
  typedef struct packed {
    logic [3:0]  gain_db;
    logic [5:0]  emphasis_tenth_db;
    logic [10:0] swing_mvpp;
  } rlp_cfg_s;

  // setting values
  localparam logic [3:0]  GAIN_FLOAT  = 4'h0;
  localparam logic [3:0]  GAIN_LOW    = 4'h7;
  localparam logic [3:0]  GAIN_HIGH   = 4'hF;
  localparam logic [10:0] SWING_FLOAT = 11'h4D9;
  localparam logic [10:0] SWING_LOW   = 11'h451;
  localparam logic [10:0] SWING_HIGH  = 11'h52C;
  // de-emphasis magnitudes in tenths of a dB, [emphasis][swing]
  localparam logic [5:0] EMPH_LOW_SF  = 6'h1E;
  localparam logic [5:0] EMPH_LOW_SL  = 6'h14;
  localparam logic [5:0] EMPH_LOW_SH  = 6'h28;
  localparam logic [5:0] EMPH_HIGH_SF = 6'h32;
  localparam logic [5:0] EMPH_HIGH_SL = 6'h28;
  localparam logic [5:0] EMPH_HIGH_SH = 6'h38;
  localparam logic [5:0] EMPH_NONE    = 6'h00;

endpackage : rlp_pkg

// *** hw/rlp_link_fsm.sv ***
// redriver link power state machine with strap decode and apb registers
`timescale 1ns/100ps
`default_nettype none

module rlp_link_fsm
  import rlp_pkg::*;
#(
  parameter int unsigned RETRY_CYCLES = RETRY_CYC,
  parameter int unsigned U2U3_CYCLES  = U2U3_IDLE_CYC
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [11:0]      paddr,
  input  wire logic [31:0]      pwdata,
  output logic [31:0]           prdata,
  output logic                  pready,
  output logic                  pslverr,
  input  wire logic             en_rxd,
  input  wire rlp_strap_s [1:0] strap_pins,
  input  wire logic             det_done,
  input  wire logic [1:0]       det_found,
  input  wire logic [1:0]       lfps_below_min,
  input  wire logic [1:0]       lfps_above_max,
  output logic                  det_req,
  output logic [1:0]            rx_term_en,
  output logic [1:0]            tx_term_en,
  output logic [1:0]            tx_idle,
  output logic [1:0]            chan_low_power,
  output logic                  sleep_mode,
  output logic                  circuits_off,
  output logic                  u2u3_power_down,
  output rlp_cfg_s [1:0]        chan_cfg
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  rlp_state_e        state;
  rlp_state_e        next_state;
  logic              en_q;
  logic [31:0]       free_cnt;
  logic [31:0]       idle_cnt;
  logic [1:0]        found;
  rlp_strap_s [1:0]  strap_q;
  rlp_cfg_s [1:0]    next_cfg;
  logic [31:0]       ctrl;
  logic [1:0]        next_rx_term;
  logic [1:0]        next_tx_term;
  logic [1:0]        next_low_power;
  logic              next_sleep;
  logic              next_off;
  logic              next_u2u3;
  logic              next_det_req;

  ////////////////////////////////////////////////////////////////////////////
  // enable pin edges and shared event terms

  wire logic en_rise    = en_rxd & ~en_q;
  wire logic en_fall    = ~en_rxd & en_q;
  wire logic retry_tick = (free_cnt == 32'(RETRY_CYCLES - 1));
  wire logic both_idle  = &tx_idle;
  wire logic u2u3_hit   = (idle_cnt == 32'(U2U3_CYCLES - 1));
  wire logic any_lfps   = |lfps_above_max;
  wire logic track_en   = ctrl[CTRL_TRACK_BIT];

  // apb decode
  wire logic apb_setup = psel & ~penable;
  wire logic apb_wr    = psel & penable & pwrite;
  wire logic hit_ctrl  = (paddr == OFF_CTRL);
  wire logic hit_stat  = (paddr == OFF_STATUS);
  wire logic hit_strap = (paddr == OFF_STRAP);
  wire logic hit_set   = (paddr == OFF_SETTING);
  wire logic hit_any   = hit_ctrl | hit_stat | hit_strap | hit_set;
  wire logic redetect  = apb_wr & hit_ctrl & pwdata[CTRL_REDETECT_BIT];

  // straps are taken once when leaving start or sleep, or on redetect
  wire logic strap_take = (next_state == RLP_ST_HIZ) &&
                          ((state == RLP_ST_START) ||
                           (state == RLP_ST_SLEEP) || redetect);

  ////////////////////////////////////////////////////////////////////////////
  // next state

  // detect sequence, sleep, and u2/u3 tracking
  always_comb begin
    next_state = state;
    case (state)
      RLP_ST_START: begin
        if (en_rxd) begin
          next_state = RLP_ST_HIZ;
        end else begin
          next_state = RLP_ST_SLEEP;
        end
      end
      RLP_ST_SLEEP: begin
        if (en_rise) begin
          next_state = RLP_ST_HIZ;
        end
      end
      RLP_ST_HIZ: begin
        next_state = RLP_ST_SENSE;
      end
      RLP_ST_SENSE: begin
        if (det_done && (&det_found)) begin
          next_state = RLP_ST_ACTIVE;
        end else if (det_done) begin
          next_state = RLP_ST_NODET;
        end
      end
      RLP_ST_NODET: begin
        if (retry_tick) begin
          next_state = RLP_ST_HIZ;
        end
      end
      RLP_ST_ACTIVE: begin
        if (u2u3_hit) begin
          next_state = RLP_ST_U2U3;
        end
      end
      RLP_ST_U2U3: begin
        if (any_lfps) begin
          next_state = RLP_ST_ACTIVE;
        end else if (retry_tick) begin
          next_state = RLP_ST_U2SENSE;
        end
      end
      RLP_ST_U2SENSE: begin
        if (det_done && (&det_found)) begin
          next_state = RLP_ST_U2U3;
        end else if (det_done) begin
          next_state = RLP_ST_HIZ;
        end
      end
      default: begin
        next_state = RLP_ST_START;
      end
    endcase
    // enable toggles override everything once past start
    if (state != RLP_ST_START) begin
      if (en_fall || (!en_rxd && state != RLP_ST_SLEEP)) begin
        next_state = RLP_ST_SLEEP;
      end else if (state != RLP_ST_SLEEP && (en_rise || redetect)) begin
        next_state = RLP_ST_HIZ;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // output decode from the next state

  // terminations follow the state entered
  assign next_rx_term = (next_state == RLP_ST_ACTIVE ||
                         next_state == RLP_ST_U2U3 ||
                         next_state == RLP_ST_U2SENSE) ?
                        2'b11 : 2'b00;
  assign next_tx_term = (next_state == RLP_ST_ACTIVE ||
                         next_state == RLP_ST_U2U3 ||
                         next_state == RLP_ST_U2SENSE) ?
                        2'b11 : 2'b00;
  // in nodet only the channel without a far end sits in low power; sleep puts both channels in low power
  // the result is live on the done edge and held in found afterwards
  assign next_low_power = (next_state == RLP_ST_SLEEP) ? 2'b11 :
                          (next_state != RLP_ST_NODET) ? 2'b00 :
                          (state == RLP_ST_NODET) ? ~found :
                          ~det_found;
  assign next_sleep   = (next_state == RLP_ST_SLEEP);
  assign next_off     = (next_state == RLP_ST_SLEEP ||
                         next_state == RLP_ST_HIZ ||
                         next_state == RLP_ST_SENSE ||
                         next_state == RLP_ST_NODET);
  assign next_u2u3    = (next_state == RLP_ST_U2U3 ||
                         next_state == RLP_ST_U2SENSE);
  assign next_det_req = (next_state == RLP_ST_SENSE ||
                         next_state == RLP_ST_U2SENSE);

  ////////////////////////////////////////////////////////////////////////////
  // state and timers

  // state register and enable pin history
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= RLP_ST_START;
      en_q  <= 1'b0;
    end else begin
      state <= next_state;
      en_q  <= en_rxd;
    end
  end

  // free-running retry counter paces both detect loops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      free_cnt <= 32'h0000_0000;
    end else if (retry_tick) begin
      free_cnt <= 32'h0000_0000;
    end else begin
      free_cnt <= free_cnt + 32'h0000_0001;
    end
  end

  // idle time on both outputs while active marks u2/u3 entry
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idle_cnt <= 32'h0000_0000;
    end else if (state != RLP_ST_ACTIVE || !both_idle || !track_en) begin
      idle_cnt <= 32'h0000_0000;
    end else if (!u2u3_hit) begin
      idle_cnt <= idle_cnt + 32'h0000_0001;
    end
  end

  // far-end result of the last detection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      found <= 2'b00;
    end else if (det_done && det_req) begin
      found <= det_found;
    end
  end

  // registered power and termination controls
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_term_en      <= 2'b00;
      tx_term_en      <= 2'b00;
      chan_low_power  <= 2'b00;
      sleep_mode      <= 1'b0;
      circuits_off    <= 1'b1;
      u2u3_power_down <= 1'b0;
      det_req         <= 1'b0;
    end else begin
      rx_term_en      <= next_rx_term;
      tx_term_en      <= next_tx_term;
      chan_low_power  <= next_low_power;
      sleep_mode      <= next_sleep;
      circuits_off    <= next_off;
      u2u3_power_down <= next_u2u3;
      det_req         <= next_det_req;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-channel electrical idle and strap decode

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_chan
      // decoded setting of this channel's three straps
      wire rlp_strap_s s = strap_q[ch];
      assign next_cfg[ch].gain_db =
        (s.input_gain_select == RLP_LVL_LOW)  ? GAIN_LOW  :
        (s.input_gain_select == RLP_LVL_HIGH) ? GAIN_HIGH :
        GAIN_FLOAT;
      assign next_cfg[ch].swing_mvpp =
        (s.output_swing_select == RLP_LVL_LOW)  ? SWING_LOW  :
        (s.output_swing_select == RLP_LVL_HIGH) ? SWING_HIGH :
        SWING_FLOAT;
      wire logic [5:0] emph_low =
        (s.output_swing_select == RLP_LVL_LOW)  ? EMPH_LOW_SL :
        (s.output_swing_select == RLP_LVL_HIGH) ? EMPH_LOW_SH :
        EMPH_LOW_SF;
      wire logic [5:0] emph_high =
        (s.output_swing_select == RLP_LVL_LOW)  ? EMPH_HIGH_SL :
        (s.output_swing_select == RLP_LVL_HIGH) ? EMPH_HIGH_SH :
        EMPH_HIGH_SF;
      assign next_cfg[ch].emphasis_tenth_db =
        (s.output_emphasis_select == RLP_LVL_LOW)  ? emph_low  :
        (s.output_emphasis_select == RLP_LVL_HIGH) ? emph_high :
        EMPH_NONE;

      // idle flag with hysteresis between the two thresholds
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          tx_idle[ch] <= 1'b1;
        end else if (lfps_below_min[ch]) begin
          tx_idle[ch] <= 1'b1;
        end else if (lfps_above_max[ch]) begin
          tx_idle[ch] <= 1'b0;
        end
      end

      // straps sampled once, setting held in flops
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          strap_q[ch]  <= '0;
          chan_cfg[ch] <= '0;
        end else begin
          if (strap_take) begin
            strap_q[ch] <= strap_pins[ch];
          end
          chan_cfg[ch] <= next_cfg[ch];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // apb slave, zero wait states

  // control register; the redetect bit is a write pulse only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= CTRL_RESET;
    end else if (apb_wr && hit_ctrl) begin
      ctrl <= {31'h0000_0000, pwdata[CTRL_TRACK_BIT]};
    end
  end

  // read data and error captured in the setup cycle
  wire logic [31:0] stat_word =
    32'({u2u3_power_down, tx_term_en, rx_term_en, sleep_mode,
         tx_idle, found, state});
  wire logic [31:0] strap_word = 32'({strap_q[1], strap_q[0]});
  wire logic [31:0] set_word   =
    {12'h000, chan_cfg[1].gain_db, chan_cfg[1].emphasis_tenth_db,
     chan_cfg[0].gain_db, chan_cfg[0].emphasis_tenth_db};
  wire logic [31:0] rd_mux =
    hit_ctrl  ? ctrl       :
    hit_stat  ? stat_word  :
    hit_strap ? strap_word :
    hit_set   ? set_word   : 32'h0000_0000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (apb_setup) begin
      prdata  <= pwrite ? 32'h0000_0000 : rd_mux;
      pslverr <= ~hit_any;
    end
  end

  assign pready = 1'b1;

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_sense_pass;
    state == RLP_ST_SENSE && det_done && (&det_found) && en_rxd && en_q;
  endsequence

  sequence s_sense_fail;
    state == RLP_ST_SENSE && det_done && !(&det_found) && en_rxd && en_q;
  endsequence

  property p_start_hiz;
    (state == RLP_ST_START && en_rxd)
      |=> (state == RLP_ST_HIZ && rx_term_en == 2'b00)
      ##1 (state != RLP_ST_SENSE || det_req);
  endproperty
  a_start_hiz: assert property (p_start_hiz)
    else $error("start did not pass through hi-z before sensing");

  property p_both_found;
    s_sense_pass |=> state == RLP_ST_ACTIVE && rx_term_en == 2'b11
                     && tx_term_en == 2'b11;
  endproperty
  a_both_found: assert property (p_both_found)
    else $error("terminations not enabled after both receivers found");

  property p_none_found;
    s_sense_fail |=> state == RLP_ST_NODET && tx_term_en == 2'b00
                     && chan_low_power == ~$past(det_found);
  endproperty
  a_none_found: assert property (p_none_found)
    else $error("failed detect did not park the channel");

  property p_retry;
    (state == RLP_ST_NODET && retry_tick && en_rxd && en_q && !redetect)
      |=> state == RLP_ST_HIZ ##1 det_req;
  endproperty
  a_retry: assert property (p_retry)
    else $error("retry tick did not restart detection");

  property p_u2_term;
    state == RLP_ST_U2SENSE |-> rx_term_en == 2'b11 && u2u3_power_down;
  endproperty
  a_u2_term: assert property (p_u2_term)
    else $error("input termination dropped during u2u3 detect");

  property p_u2_fail;
    (state == RLP_ST_U2SENSE && det_done && !(&det_found) && en_rxd && en_q)
      |=> state == RLP_ST_HIZ && rx_term_en == 2'b00;
  endproperty
  a_u2_fail: assert property (p_u2_fail)
    else $error("u2u3 detect failure did not restart detection");

  property p_idle_entry;
    lfps_below_min[0] |=> tx_idle[0];
  endproperty
  a_idle_entry: assert property (p_idle_entry)
    else $error("channel 0 output not idle after quiet input");

  property p_idle_exit;
    (lfps_above_max[1] && !lfps_below_min[1]) |=> !tx_idle[1];
  endproperty
  a_idle_exit: assert property (p_idle_exit)
    else $error("channel 1 output stayed idle after activity");

  property p_sleep;
    (en_fall && state != RLP_ST_START)
      |=> sleep_mode && rx_term_en == 2'b00 && tx_term_en == 2'b00;
  endproperty
  a_sleep: assert property (p_sleep)
    else $error("sleep entry incomplete after enable fell");

  property p_wake;
    (state == RLP_ST_SLEEP && en_rise) |=> ##[0:1] det_req;
  endproperty
  a_wake: assert property (p_wake)
    else $error("sleep exit did not start detection");

  property p_lfps_wake;
    (state == RLP_ST_U2U3 && any_lfps && en_rxd && en_q && !redetect)
      |=> state == RLP_ST_ACTIVE && !u2u3_power_down;
  endproperty
  a_lfps_wake: assert property (p_lfps_wake)
    else $error("lfps activity did not wake the link");

endmodule : rlp_link_fsm

`default_nettype wire

// *** verif/rlp_far_end_model.sv ***
// far-end model: receiver-detect answers and lfps comparator levels
`timescale 1ns/100ps
`default_nettype none
module rlp_far_end_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       det_req,
  input  wire logic [1:0] present,
  input  wire logic [1:0] line_idle,
  input  wire logic       slow,
  output logic            det_done,
  output logic [1:0]      det_found,
  output logic [1:0]      lfps_below_min,
  output logic [1:0]      lfps_above_max
);
  logic [2:0] cnt;

  // found bits are only meaningful with the done pulse, garbage otherwise
  assign det_found = det_done ? present : ~present;
  // controller side idle line sits below the low threshold
  assign lfps_below_min = line_idle;
  assign lfps_above_max = ~line_idle;

  // answer a pending detect request after one or five cycles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt      <= 3'h0;
      det_done <= 1'b0;
    end else if (det_req && !det_done) begin
      det_done <= (cnt == (slow ? 3'h4 : 3'h0));
      cnt      <= cnt + 3'h1;
    end else begin
      det_done <= 1'b0;
      cnt      <= 3'h0;
    end
  end
endmodule : rlp_far_end_model
`default_nettype wire

// *** verif/rlp_link_fsm_tb_top.sv ***
// testbench: apb accesses, detect, idle, low-power and strap sequences
`timescale 1ns/100ps
`default_nettype none
module rlp_link_fsm_tb_top;
  import rlp_pkg::*;
  localparam int unsigned RETRY = 64;
  localparam int unsigned U2U3  = 16;
  logic             pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0]      paddr;
  logic [31:0]      pwdata, prdata, q;
  logic             en_rxd, det_done, det_req, sleep_mode, circuits_off;
  logic             u2u3_power_down, slow, e;
  logic [1:0]       det_found, lfps_below_min, lfps_above_max, rx_term_en;
  logic [1:0]       tx_term_en, tx_idle, chan_low_power, present, line_idle;
  logic [2:0]       mon;
  rlp_strap_s [1:0] strap_pins;
  rlp_cfg_s [1:0]   chan_cfg;
  int               miscompares, total_checks, cycles, n;

  assign mon = {u2u3_power_down, sleep_mode, det_req};

  rlp_link_fsm #(.RETRY_CYCLES(RETRY), .U2U3_CYCLES(U2U3)) i_rlp_link_fsm (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .en_rxd(en_rxd),
    .strap_pins(strap_pins), .det_done(det_done), .det_found(det_found),
    .lfps_below_min(lfps_below_min), .lfps_above_max(lfps_above_max),
    .det_req(det_req), .rx_term_en(rx_term_en), .tx_term_en(tx_term_en),
    .tx_idle(tx_idle), .chan_low_power(chan_low_power),
    .sleep_mode(sleep_mode), .circuits_off(circuits_off),
    .u2u3_power_down(u2u3_power_down), .chan_cfg(chan_cfg));

  rlp_far_end_model i_rlp_far_end_model (
    .pclk(pclk), .presetn(presetn), .det_req(det_req), .present(present),
    .line_idle(line_idle), .slow(slow), .det_done(det_done),
    .det_found(det_found), .lfps_below_min(lfps_below_min),
    .lfps_above_max(lfps_above_max));

  ////////////////////////////////////////////////////////////////////////////
  // clock and hang guard
  always #2 pclk = ~pclk;
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      end_of_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // wait for a monitored flag to reach a level, bounded
  task automatic wait_on(input int k, input logic v, input int lim);
    n = 0;
    while (mon[k] !== v && n < lim) begin
      @(posedge pclk);
      n++;
    end
    chk(32'(mon[k] === v), 32'h0000_0001);
  endtask : wait_on

  // one apb transfer: setup, access until pready, then release
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  function automatic logic [1:0] lv(input int x);
    return 2'(x);
  endfunction : lv

  // expected setting per strap level index: 0 float, 1 low, 2 high
  function automatic rlp_cfg_s exp_cfg(input int g, input int m, input int s);
    logic [3:0]  gt [3] = '{4'h0, 4'h7, 4'hF};
    logic [5:0]  et [9] = '{6'h00, 6'h00, 6'h00, 6'h1E, 6'h14, 6'h28,
                            6'h32, 6'h28, 6'h38};
    logic [10:0] st [3] = '{11'h4D9, 11'h451, 11'h52C};
    return {gt[g], et[m*3+s], st[s]};
  endfunction : exp_cfg

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    en_rxd = 1'b1;
    present = 2'b11;
    line_idle = 2'b00;
    slow = 1'b0;
    strap_pins = 12'h625;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    wait_on(0, 1'b1, 4);
    chk(n, 3);
    chk(rx_term_en, 2'b00);
    wait_on(0, 1'b0, 8);
    chk({rx_term_en, tx_term_en, chan_low_power, circuits_off}, 7'h78);
    apb(1'b0, OFF_CTRL, 32'h0000_0000);
    chk(q, 32'h0000_0001);
    apb(1'b1, OFF_STATUS, 32'h0000_0000);
    apb(1'b0, OFF_STATUS, 32'h0000_0000);
    chk(q & 32'h0000_1F07, 32'h0000_0F05);
    apb(1'b0, 12'h010, 32'h0000_0000);
    chk({31'h0, e}, 32'h0000_0001);
    chk(q, 32'h0000_0000);
    apb(1'b0, OFF_STRAP, 32'h0000_0000);
    chk(q, {20'h0_0000, strap_pins});
    // idle entry and exit within two cycles
    line_idle <= 2'b01;
    repeat (2) @(posedge pclk);
    chk(tx_idle, 2'b01);
    line_idle <= 2'b00;
    repeat (2) @(posedge pclk);
    chk(tx_idle, 2'b00);
    // u2/u3 entry, periodic detect pass, lfps wake
    line_idle <= 2'b11;
    wait_on(2, 1'b1, U2U3 + 4);
    chk({rx_term_en, tx_term_en}, 4'hF);
    wait_on(0, 1'b1, RETRY + 4);
    chk(rx_term_en, 2'b11);
    wait_on(0, 1'b0, 8);
    chk(u2u3_power_down, 1'b1);
    line_idle <= 2'b10;
    repeat (2) @(posedge pclk);
    chk(u2u3_power_down, 1'b0);
    // u2/u3 detect fails, then power-up detect fails
    line_idle <= 2'b11;
    wait_on(2, 1'b1, U2U3 + 4);
    present <= 2'b00;
    wait_on(0, 1'b1, RETRY + 4);
    wait_on(0, 1'b0, 8);
    chk(rx_term_en, 2'b00);
    wait_on(0, 1'b1, 4);
    wait_on(0, 1'b0, 8);
    chk({tx_term_en, chan_low_power, rx_term_en, circuits_off},
        7'h19);
    present <= 2'b01;
    wait_on(0, 1'b1, RETRY + 4);
    wait_on(0, 1'b0, 8);
    repeat (2) @(posedge pclk);
    chk(chan_low_power, 2'b10);
    present <= 2'b11;
    slow <= 1'b1;
    line_idle <= 2'b00;
    wait_on(0, 1'b1, RETRY + 4);
    wait_on(0, 1'b0, 12);
    chk({rx_term_en, tx_term_en}, 4'hF);
    apb(1'b1, OFF_CTRL, 32'h0000_0003);
    wait_on(0, 1'b1, 4);
    wait_on(0, 1'b0, 12);
    apb(1'b0, OFF_CTRL, 32'h0000_0000);
    chk(q, 32'h0000_0001);
    // sleep and wake with all nine emphasis and swing strap pairs on each channel
    for (int i = 0; i < 9; i++) begin
      strap_pins <= {lv((i + 1) % 3), lv((i + 2) % 3), lv(i / 3),
                     lv(i % 3), lv(i / 3), lv(i % 3)};
      en_rxd <= 1'b0;
      wait_on(1, 1'b1, SLEEP_ENTRY_CYC);
      chk({rx_term_en, tx_term_en}, 4'h0);
      en_rxd <= 1'b1;
      wait_on(0, 1'b1, WAKE_CYC);
      chk(chan_cfg[0], exp_cfg(i % 3, i / 3, i % 3));
      chk(chan_cfg[1], exp_cfg((i + 1) % 3, (i + 2) % 3, i / 3));
      wait_on(0, 1'b0, 12);
    end
    // last loop pass: ch0 high/high/high, ch1 float/low/high
    apb(1'b0, OFF_SETTING, 32'h0000_0000);
    chk(q, 32'h0000_A3F8);
    // power-up with the enable pin low goes straight to sleep
    en_rxd <= 1'b0;
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    wait_on(1, 1'b1, 4);
    chk({rx_term_en, tx_term_en}, 4'h0);
    end_of_test();
  end
endmodule : rlp_link_fsm_tb_top
`default_nettype wire
